// ==== rtl/ext_bus_if.v ====
// external memory bus interface: code fetch, data moves, on-chip xram
// assumes the core raises a request for one cycle and waits for done
// Behaviour
// - A low external fetch select sends every code fetch to the external bus.
// - With the select high, fetches below 32 KB stay on chip and never show on the bus.
// - The program fetch strobe is driven low during external code fetches and external code table reads.
// - The program fetch strobe stays high for accesses served on chip.
// - An address latch strobe pulses in every external access before data appears.
// - The low port carries the low address byte and then the data byte.
// - The high port carries the upper eight address bits during external accesses.
// - Data moves use separate write and read strobes.
// - Data and code phases are counted in machine cycles of four clocks; the address cycle takes two to five clocks by alignment.
// - A wait input, when enabled, stretches external accesses while it is low.
// - A 1 KB on-chip data RAM is reached only by data moves.
// - The on-chip data RAM answers 0000h to 03ffh only while its enable input is high; reset does not clear that input.
// - An external data move lasts two to nine machine cycles as programmed.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_regs.vh"
module ext_bus_if #(
  parameter XRAM_DEPTH = 1024
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        external_fetch_select_n,
  input  wire        onchip_xram_enable,
  input  wire [3:0]  data_move_stretch,
  input  wire        wait_enable,
  input  wire        wait_in_n,
  input  wire        req,
  input  wire [1:0]  req_kind,
  input  wire [15:0] req_addr,
  input  wire [7:0]  req_wdata,
  input  wire [7:0]  rom_rdata,
  output reg         done,
  output reg  [7:0]  rdata,
  output reg         rom_sel,
  output reg  [14:0] rom_addr,
  output reg  [7:0]  ad_out,
  output reg         ad_oe,
  input  wire [7:0]  ad_in,
  output reg  [7:0]  addr_hi,
  output reg         ale,
  output reg         program_fetch_strobe_n,
  output reg         wr_n,
  output reg         rd_n
);
  localparam K_FETCH = 2'h0;
  localparam K_TABLE = 2'h1;
  localparam K_XRD   = 2'h2;
  localparam K_XWR   = 2'h3;
  localparam S_IDLE  = 3'h0;
  localparam S_ADDR  = 3'h1;
  localparam S_CODE  = 3'h2;
  localparam S_DATA  = 3'h3;
  localparam S_END   = 3'h4;
  localparam S_ROM   = 3'h5;
  // ----------------------------------------------------------------
  // machine cycle timing
  // ----------------------------------------------------------------
  wire       mc_end;
  // free running: the address cycle takes two to five clocks by alignment
  mcyc_phase #(.CLKS(`CLKS_PER_MCYC)) u_phase (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .phase_reg  (),
    .last_phase (mc_end)
  );
  // ----------------------------------------------------------------
  // access classification
  // ----------------------------------------------------------------
  localparam [15:0] ROM_TOP  = `ONCHIP_ROM_TOP;
  localparam [15:0] XRAM_TOP = `XRAM_LAST;
  localparam [3:0]  MOVE_MIN = `DATA_MOVE_MIN_MCYC;
  localparam [3:0]  MOVE_MAX = `DATA_MOVE_MAX_MCYC;
  reg  [2:0]  state_reg;
  reg  [1:0]  kind_reg;
  reg  [7:0]  wdata_reg;
  reg  [3:0]  mc_cnt_reg;
  reg  [3:0]  stretch;
  reg         is_code;
  wire        take        = req && (state_reg == S_IDLE) && !done;
  wire        code_onchip = external_fetch_select_n && (req_addr <= ROM_TOP);
  wire        data_onchip = onchip_xram_enable && (req_addr <= XRAM_TOP);
  wire        held        = wait_enable && !wait_in_n;
  wire        move_last   = (mc_cnt_reg >= stretch - 4'h1);
  wire        kind_code   = (kind_reg == K_FETCH) || (kind_reg == K_TABLE);
  wire        kind_read   = (kind_reg == K_XRD);
  wire        kind_write  = (kind_reg == K_XWR);
  always @* begin
    case (req_kind)
      K_FETCH: is_code = 1'b1;
      K_TABLE: is_code = 1'b1;
      default: is_code = 1'b0;
    endcase
  end
  // settings outside two to nine are pulled back into range
  always @* begin
    if (data_move_stretch < MOVE_MIN) begin
      stretch = MOVE_MIN;
    end else if (data_move_stretch > MOVE_MAX) begin
      stretch = MOVE_MAX;
    end else begin
      stretch = data_move_stretch;
    end
  end
  // ----------------------------------------------------------------
  // on-chip data ram
  // ----------------------------------------------------------------
  // not reset: contents are undefined until written
  reg  [7:0] xram [0:XRAM_DEPTH-1];
  wire [9:0] xidx = req_addr[9:0];
  wire       xram_write = take && (req_kind == K_XWR) && data_onchip;
  always @(posedge mclk) begin
    if (xram_write) begin
      xram[xidx] <= req_wdata;
    end
  end
  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg              <= S_IDLE;
      kind_reg               <= 2'h0;
      wdata_reg              <= 8'h00;
      mc_cnt_reg             <= 4'h0;
      done                   <= 1'b0;
      rdata                  <= 8'h00;
      rom_sel                <= 1'b0;
      rom_addr               <= 15'h0000;
      ad_out                 <= 8'h00;
      ad_oe                  <= 1'b0;
      addr_hi                <= 8'h00;
      ale                    <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      wr_n                   <= 1'b1;
      rd_n                   <= 1'b1;
    end else begin
      done    <= 1'b0;
      rom_sel <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            kind_reg  <= req_kind;
            wdata_reg <= req_wdata;
            if (is_code && code_onchip) begin
              rom_sel   <= 1'b1;
              rom_addr  <= req_addr[14:0];
              state_reg <= S_ROM;
            end else if (!is_code && data_onchip) begin
              rdata     <= xram[xidx];
              done      <= 1'b1;
            end else begin
              // address goes out with the latch strobe at once
              ad_out    <= req_addr[7:0];
              ad_oe     <= 1'b1;
              addr_hi   <= req_addr[15:8];
              ale       <= 1'b1;
              state_reg <= S_ADDR;
            end
          end
        end
        S_ROM: begin
          rdata     <= rom_rdata;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_ADDR: begin
          // latch strobe falls a clock before the port may turn to data
          ale        <= 1'b0;
          mc_cnt_reg <= 4'h1;
          if (mc_end && !ale) begin
            if (kind_code) begin
              ad_oe                  <= 1'b0;
              program_fetch_strobe_n <= 1'b0;
              state_reg              <= S_CODE;
            end else begin
              ad_out    <= wdata_reg;
              ad_oe     <= kind_write;
              wr_n      <= !kind_write;
              rd_n      <= !kind_read;
              state_reg <= S_DATA;
            end
          end
        end
        S_CODE: begin
          // wait is looked at only where a machine cycle ends
          if (mc_end && !held) begin
            rdata                  <= ad_in;
            program_fetch_strobe_n <= 1'b1;
            state_reg              <= S_END;
          end
        end
        S_DATA: begin
          if (mc_end) begin
            // count saturates so a long wait cannot wrap it below the length
            if (mc_cnt_reg != 4'hf) begin
              mc_cnt_reg <= mc_cnt_reg + 4'h1;
            end
            if (move_last && !held) begin
              rdata     <= ad_in;
              wr_n      <= 1'b1;
              rd_n      <= 1'b1;
              state_reg <= S_END;
            end
          end
        end
        S_END: begin
          ad_oe     <= 1'b0;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ext_bus_regs.vh ====
// constants of the external memory bus interface
// assumes inclusion by its bare name from the rtl files
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH
`define CLKS_PER_MCYC      4
`define ONCHIP_ROM_TOP     16'h7fff
`define XRAM_LAST          16'h03ff
`define DATA_MOVE_MIN_MCYC 4'h2
`define DATA_MOVE_MAX_MCYC 4'h9
`define RESET_HOLD_MCYC    2
`endif

// ==== rtl/mcyc_phase.v ====
// machine cycle phase counter, four clocks per machine cycle
// assumes one free running clock
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_regs.vh"
module mcyc_phase #(
  parameter CLKS = `CLKS_PER_MCYC
) (
  input  wire       mclk,
  input  wire       rst_n,
  output reg  [1:0] phase_reg,
  output wire       last_phase
);
  assign last_phase = (phase_reg == CLKS - 1);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
    end else if (last_phase) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/ext_bus_properties.sv ====
// checker for the external bus interface
// bound to every ext_bus_if instance
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chk(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        external_fetch_select_n,
  input wire logic        req,
  input wire logic [1:0]  req_kind,
  input wire logic [15:0] req_addr,
  input wire logic        done,
  input wire logic        rom_sel,
  input wire logic        ad_oe,
  input wire logic        ale,
  input wire logic        program_fetch_strobe_n,
  input wire logic        wr_n,
  input wire logic        rd_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire fetch = req && req_kind == 2'h0;
  rom_quiet_a: assert property (rom_sel |-> program_fetch_strobe_n) else $error("rom strobe");
  rom_fetch_a: assert property (fetch && external_fetch_select_n && !req_addr[15] |=> rom_sel ##1 done)
    else $error("no rom fetch");
  ext_fetch_a: assert property (fetch && !external_fetch_select_n |-> ##[2:12] !program_fetch_strobe_n)
    else $error("no ext fetch");
  read_float_a: assert property (!(rd_n && program_fetch_strobe_n) |-> !ad_oe) else $error("port driven");
  write_drive_a: assert property (!wr_n |-> ad_oe) else $error("port idle");
  strobe_excl_a: assert property ($onehot0({!rd_n, !wr_n, !program_fetch_strobe_n})) else $error("overlap");
  ale_first_a: assert property (ale |-> rd_n && wr_n && program_fetch_strobe_n) else $error("late ale");
  done_pulse_a: assert property (done |=> !done) else $error("long done");
  ale_pulse_a: assert property (ale |=> !ale) else $error("long ale");
  ale_drive_a: assert property (ale |-> ad_oe) else $error("address not driven");
endmodule
bind ext_bus_if ext_bus_chk chk (.*);
`default_nettype wire

// ==== bench/ext_mem_model.sv ====
// far side: external memory behind an address latch, plus rom data
// assumes the ext_bus_if pins
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model(
  input wire logic        mclk,
  input wire logic        ale,
  input wire logic        program_fetch_strobe_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [7:0]  ad_out,
  input wire logic [7:0]  addr_hi,
  input wire logic [14:0] rom_addr,
  output var logic [7:0]  ad_in,
  output var logic [7:0]  rom_rdata
);
  logic [7:0] mem [65536];
  logic [7:0] lo;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i + (i >> 8));
  always @(negedge ale) lo = ad_out;
  always @(negedge mclk) if (!wr_n) mem[{addr_hi, lo}] = ad_out;
  // released port shows the inverse of its last value
  always @(rd_n, program_fetch_strobe_n) ad_in = rd_n && program_fetch_strobe_n ? ~ad_in : mem[{addr_hi, lo}];
  always @* rom_rdata = rom_addr[7:0] ^ 8'h5a;
endmodule
`default_nettype wire

// ==== bench/external_memory_bus_interface_test.sv ====
// self-checking bench for ext_bus_if
// assumes ext_mem_model on the far side
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface_test;
  typedef struct packed {logic [1:0] k, m; logic [15:0] a; logic [7:0] d, e; logic x;} row_t;
  logic mclk = 0, rst_n = 0, fsel_n = 1, xen = 0, wen = 0, wait_n = 1, req = 0;
  logic [3:0] stretch = 4'h2;
  logic [1:0] kind = 2'h0;
  logic [15:0] addr = 16'h0;
  logic [7:0] wd = 8'h0, ad_in, rom_rdata, rdata, ad_out, addr_hi;
  logic done, rom_sel, ad_oe, ale, fetch_n, wr_n, rd_n;
  logic [14:0] rom_addr;
  int fails = 0, tests_run = 0, lo, seen, base, nale;
  row_t rows [10] = '{'{0, 2, 16'h0012, 0, 8'h48, 0}, '{0, 0, 16'h0012, 0, 8'h12, 1},
    '{0, 2, 16'h8034, 0, 8'hb4, 1}, '{1, 2, 16'h1234, 0, 8'h6e, 0}, '{3, 2, 16'h0100, 8'ha5, 0, 1},
    '{2, 2, 16'h0100, 0, 8'ha5, 1}, '{3, 3, 16'h0200, 8'h3c, 0, 0}, '{2, 3, 16'h0200, 0, 8'h3c, 0},
    '{2, 2, 16'h0200, 0, 8'h02, 1}, '{2, 3, 16'h0400, 0, 8'h04, 1}};
  always #20 mclk = ~mclk;
  ext_bus_if dut(.mclk, .rst_n, .external_fetch_select_n(fsel_n), .onchip_xram_enable(xen),
    .data_move_stretch(stretch), .wait_enable(wen), .wait_in_n(wait_n), .req, .req_kind(kind), .req_addr(addr),
    .req_wdata(wd), .rom_rdata, .done, .rdata, .rom_sel, .rom_addr, .ad_out, .ad_oe, .ad_in, .addr_hi, .ale,
    .program_fetch_strobe_n(fetch_n), .wr_n, .rd_n);
  ext_mem_model mem(.mclk, .ale, .program_fetch_strobe_n(fetch_n), .rd_n, .wr_n, .ad_out, .addr_hi, .rom_addr,
    .ad_in, .rom_rdata);
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task summarize;
    $display("tests %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic access(logic [1:0] k, logic [15:0] a, logic [7:0] d);
    @(posedge mclk);
    req <= 1;
    kind <= k;
    addr <= a;
    wd <= d;
    @(posedge mclk) req <= 0;
    lo = 0;
    seen = 0;
    nale = 0;
    for (int n = 0; n < 99 && done !== 1'b1; n++) begin
      @(negedge mclk);
      if (ale) check("latched addr", a, {addr_hi, ad_out});
      lo += !rd_n || !wr_n;
      seen += !fetch_n;
      nale += ale;
      if (n == 20) wait_n <= 1;
    end
    if (done !== 1'b1) begin
      fails++;
      summarize;
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    foreach (rows[i]) begin
      @(posedge mclk) {fsel_n, xen} <= rows[i].m;
      access(rows[i].k, rows[i].a, rows[i].d);
      if (rows[i].k != 2'h3) check("rdata", rows[i].e, rdata);
      check("bus used", rows[i].x, seen + lo > 0);
      check("latch strobe", rows[i].x, nale == 1);
      $display("row %0d done", i);
    end
    base = lo;
    @(posedge mclk) stretch <= 4'h9;
    access(2'h2, 16'h0400, 8'h0);
    check("move length", base + 28, lo);
    @(posedge mclk) stretch <= 4'h2;
    wen <= 1;
    wait_n <= 0;
    access(2'h2, 16'h0400, 8'h0);
    check("wait stretch", 1, lo > base);
    $display("stretch and wait done");
    @(posedge mclk) rst_n <= 0;
    repeat (12) @(posedge mclk);
    check("reset outputs", 5'h0e, {ale, fetch_n, wr_n, rd_n, done});
    @(posedge mclk) rst_n <= 1;
    access(2'h1, 16'h0012, 8'h00);
    check("after reset", 8'h48, rdata);
    $display("reset done");
    summarize;
  end
endmodule
`default_nettype wire
